// ---- core/dioc_pkg.sv ----
// package for the drive io port configuration block
// assumes a single 25 MHz clock and apb register access
package dioc_pkg;
	localparam int          NUM_IN        = 4;
	localparam int          NUM_OUT       = 2;
	// register byte addresses
	localparam logic [11:0] ADDR_IN_CFG   = 12'h000; // +4*i, one per input
	localparam logic [11:0] ADDR_IN_CNT   = 12'h010; // +4*i
	localparam logic [11:0] ADDR_LATCH    = 12'h020; // +4*i
	localparam logic [11:0] ADDR_IN_STATE = 12'h030;
	localparam logic [11:0] ADDR_ANA_RNG  = 12'h034;
	localparam logic [11:0] ADDR_OUT_CFG  = 12'h040; // +16*j
	localparam logic [11:0] ADDR_OUT_TIME = 12'h044; // pulse time / pwm period
	localparam logic [11:0] ADDR_OUT_ON   = 12'h048; // pwm high time
	localparam logic [11:0] ADDR_OUT_DLY  = 12'h04c; // pwm on delay
	// input config fields
	localparam int          IC_POL        = 0;  // 1 = active high
	localparam int          IC_CNT_EN     = 1;
	localparam int          IC_CNT_EDGE   = 2;  // 2 bits
	localparam int          IC_LAT_EN     = 4;
	localparam int          IC_LAT_EDGE   = 5;  // 2 bits
	localparam int          IC_CNT_CLR    = 7;  // write one to clear
	localparam int          IC_DEB        = 16; // 16 bit debounce cycles
	// output config fields
	localparam int          OC_POL        = 0;
	localparam int          OC_TYPE       = 1;  // 2 bits
	localparam int          OC_CMD        = 3;
	localparam int          OC_ACTIVE     = 4;  // read only
	localparam logic [1:0]  EDGE_NONE     = 2'h0;
	localparam logic [1:0]  EDGE_FALL     = 2'h1;
	localparam logic [1:0]  EDGE_RISE     = 2'h2;
	localparam logic [1:0]  EDGE_ANY      = 2'h3;
	typedef enum logic [1:0] {OUT_STATE = 2'h0, OUT_PULSE = 2'h1, OUT_PWM = 2'h2} dioc_type_t;
	typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_DELAY = 2'h1, PH_RUN = 2'h3} dioc_phase_t;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
endpackage : dioc_pkg

// ---- core/dioc_top.sv ----
// digital io block: input polarity, debounce, edge count, position latch;
// outputs with polarity and state, pulse or pwm type.
// assumes apb master on REF_CLK and inputs synchronous to REF_CLK.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - active-high input: high level means activated
// - active-low input: open or 0V means activated
// - counter counts falling, rising or any edges
// - latch captures axis position on selected edge
// - general inputs ignore changes during debounce time
// - analog inputs hold ten-volt or current range
// - output pin level follows active polarity setting
// - output type: state, pulse or pwm
// - type change accepted only while output inactive
// - state type holds last commanded state
// - pulse type returns inactive after pulse time
// - pwm with on-delay, period and duty settings
module dioc_top (
	input  wire logic                         REF_CLK,
	input  wire logic                         RESET_N,
	input  wire logic [11:0]                  PADDR,
	input  wire logic                         PSEL,
	input  wire logic                         PENABLE,
	input  wire logic                         PWRITE,
	input  wire logic [31:0]                  PWDATA,
	output var  logic [31:0]                  PRDATA,
	output var  logic                         PREADY,
	output var  logic                         PSLVERR,
	input  wire logic [dioc_pkg::NUM_IN-1:0]  GENERAL_INPUT_N,
	input  wire logic [31:0]                  AXIS_POSITION,
	output var  logic [dioc_pkg::NUM_OUT-1:0] GENERAL_OUTPUT,
	output var  logic [1:0]                   ANALOG_RANGE_SEL
);
	localparam int NI = dioc_pkg::NUM_IN;
	localparam int NO = dioc_pkg::NUM_OUT;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0]          in_cfg    [NI];
	logic [31:0]          in_cnt    [NI];
	logic [31:0]          latch_val [NI];
	logic [NI-1:0]        latch_full;
	logic [NI-1:0]        in_state;
	logic [NI-1:0]        in_prev;
	logic [15:0]          deb_cnt   [NI];
	logic [1:0]           ana_rng;
	logic [31:0]          out_cfg   [NO];
	logic [31:0]          out_time  [NO];
	logic [31:0]          out_on    [NO];
	logic [31:0]          out_dly   [NO];
	logic [NO-1:0]        out_act;
	logic [31:0]          out_cnt   [NO];
	dioc_pkg::dioc_phase_t out_ph   [NO];
	logic [31:0]          rdata;
	logic                 ready;
	logic                 slverr;
	logic [NO-1:0]        pin;

	logic [31:0]          next_in_cfg    [NI];
	logic [31:0]          next_in_cnt    [NI];
	logic [31:0]          next_latch_val [NI];
	logic [NI-1:0]        next_latch_full;
	logic [NI-1:0]        next_in_state;
	logic [15:0]          next_deb_cnt   [NI];
	logic [1:0]           next_ana_rng;
	logic [31:0]          next_out_cfg   [NO];
	logic [31:0]          next_out_time  [NO];
	logic [31:0]          next_out_on    [NO];
	logic [31:0]          next_out_dly   [NO];
	logic [NO-1:0]        next_out_act;
	logic [31:0]          next_out_cnt   [NO];
	dioc_pkg::dioc_phase_t next_out_ph   [NO];
	logic [31:0]          next_rdata;
	logic                 next_ready;
	logic                 next_slverr;
	logic [NO-1:0]        next_pin;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// one-wait-state apb: answer in the second cycle of the access phase
	always_comb begin
		logic          acc;
		logic          wr;
		logic          rd_hit;
		logic [11:0]   a;
		logic [NI-1:0] pol_in;
		logic          rise;
		logic          fall;
		logic          hit;
		logic [1:0]    ce;
		logic [1:0]    le;
		dioc_pkg::dioc_type_t ty;
		acc    = PSEL && PENABLE && !ready;
		// write lands at the edge where the master sees PREADY high
		wr     = PSEL && PENABLE && ready && PWRITE;
		a      = PADDR;
		pol_in = '0;
		rd_hit = 1'b0;
		rise   = 1'b0;
		fall   = 1'b0;
		hit    = 1'b0;
		ce     = 2'h0;
		le     = 2'h0;
		ty     = dioc_pkg::OUT_STATE;
		next_rdata      = dioc_pkg::RST_WORD;
		next_ready      = acc;
		next_slverr     = 1'b0;
		next_latch_full = latch_full;
		next_ana_rng    = ana_rng;
		next_out_act    = out_act;
		next_in_state   = in_state;
		next_pin        = pin;
		for (int i = 0; i < NI; i++) begin
			// raw pin to active level by polarity
			pol_in[i] = in_cfg[i][dioc_pkg::IC_POL] ? GENERAL_INPUT_N[i] : !GENERAL_INPUT_N[i];
			next_in_cfg[i]    = in_cfg[i];
			next_in_cnt[i]    = in_cnt[i];
			next_latch_val[i] = latch_val[i];
			next_deb_cnt[i]   = deb_cnt[i];
			// debounce: after any accepted change, freeze for the set cycles
			if (deb_cnt[i] != 16'h0000) begin
				next_deb_cnt[i] = deb_cnt[i] - 16'h0001;
			end else if (pol_in[i] != in_state[i]) begin
				next_in_state[i] = pol_in[i];
				next_deb_cnt[i]  = in_cfg[i][dioc_pkg::IC_DEB +: 16];
			end
			rise = in_state[i] && !in_prev[i];
			fall = !in_state[i] && in_prev[i];
			ce   = in_cfg[i][dioc_pkg::IC_CNT_EDGE +: 2];
			le   = in_cfg[i][dioc_pkg::IC_LAT_EDGE +: 2];
			hit  = (ce == dioc_pkg::EDGE_RISE && rise) || (ce == dioc_pkg::EDGE_FALL && fall)
				|| (ce == dioc_pkg::EDGE_ANY && (rise || fall));
			if (in_cfg[i][dioc_pkg::IC_CNT_EN] && hit) begin
				next_in_cnt[i] = in_cnt[i] + 32'h0000_0001;
			end
			hit = (le == dioc_pkg::EDGE_RISE && rise) || (le == dioc_pkg::EDGE_FALL && fall)
				|| (le == dioc_pkg::EDGE_ANY && (rise || fall));
			// first edge wins; later edges wait for read or re-arm
			if (in_cfg[i][dioc_pkg::IC_LAT_EN] && hit && !latch_full[i]) begin
				next_latch_val[i]  = AXIS_POSITION;
				next_latch_full[i] = 1'b1;
			end
			if (wr && a == dioc_pkg::ADDR_IN_CFG + 12'(4 * i)) begin
				next_in_cfg[i]     = PWDATA & ~(32'h1 << dioc_pkg::IC_CNT_CLR);
				// a capture in the same cycle wins over the re-arm
				next_latch_full[i] = next_latch_full[i] && !latch_full[i];
				if (PWDATA[dioc_pkg::IC_CNT_CLR]) begin
					next_in_cnt[i] = dioc_pkg::RST_WORD;
				end
			end
			if (acc && !PWRITE) begin
				if (a == dioc_pkg::ADDR_IN_CFG + 12'(4 * i)) begin
					next_rdata = in_cfg[i];
					rd_hit     = 1'b1;
				end
				if (a == dioc_pkg::ADDR_IN_CNT + 12'(4 * i)) begin
					next_rdata = in_cnt[i];
					rd_hit     = 1'b1;
				end
				if (a == dioc_pkg::ADDR_LATCH + 12'(4 * i)) begin
					next_rdata         = latch_val[i];
					next_latch_full[i] = next_latch_full[i] && !latch_full[i];
					rd_hit             = 1'b1;
				end
			end
		end
		if (wr && a == dioc_pkg::ADDR_ANA_RNG) begin
			next_ana_rng = PWDATA[1:0];
		end
		for (int j = 0; j < NO; j++) begin
			next_out_cfg[j]  = out_cfg[j];
			next_out_time[j] = out_time[j];
			next_out_on[j]   = out_on[j];
			next_out_dly[j]  = out_dly[j];
			next_out_cnt[j]  = out_cnt[j];
			next_out_ph[j]   = out_ph[j];
			ty = dioc_pkg::dioc_type_t'(out_cfg[j][dioc_pkg::OC_TYPE +: 2]);
			if (wr && a == dioc_pkg::ADDR_OUT_CFG + 12'(16 * j)) begin
				next_out_cfg[j][dioc_pkg::OC_POL] = PWDATA[dioc_pkg::OC_POL];
				next_out_cfg[j][dioc_pkg::OC_CMD] = PWDATA[dioc_pkg::OC_CMD];
				// type write ignored while active
				if (!out_act[j] && !PWDATA[dioc_pkg::OC_CMD] && PWDATA[dioc_pkg::OC_TYPE +: 2] != 2'h3) begin
					next_out_cfg[j][dioc_pkg::OC_TYPE +: 2] = PWDATA[dioc_pkg::OC_TYPE +: 2];
				end
				if (PWDATA[dioc_pkg::OC_CMD] && !out_act[j]) begin
					next_out_ph[j]  = (ty == dioc_pkg::OUT_PWM) ? dioc_pkg::PH_DELAY : dioc_pkg::PH_RUN;
					next_out_cnt[j] = 32'h0000_0000;
				end
				if (!PWDATA[dioc_pkg::OC_CMD]) begin
					next_out_ph[j] = dioc_pkg::PH_IDLE;
				end
			end
			if (wr && a == dioc_pkg::ADDR_OUT_TIME + 12'(16 * j)) next_out_time[j] = PWDATA;
			if (wr && a == dioc_pkg::ADDR_OUT_ON + 12'(16 * j)) next_out_on[j] = PWDATA;
			if (wr && a == dioc_pkg::ADDR_OUT_DLY + 12'(16 * j)) next_out_dly[j] = PWDATA;
			case (out_ph[j])
				dioc_pkg::PH_IDLE: begin
					next_out_act[j] = 1'b0;
				end
				dioc_pkg::PH_DELAY: begin
					next_out_act[j] = 1'b0;
					next_out_cnt[j] = out_cnt[j] + 32'h0000_0001;
					if (out_cnt[j] + 32'h0000_0001 >= out_dly[j]) begin
						next_out_ph[j]  = dioc_pkg::PH_RUN;
						next_out_cnt[j] = 32'h0000_0000;
					end
				end
				dioc_pkg::PH_RUN: begin
					next_out_cnt[j] = out_cnt[j] + 32'h0000_0001;
					if (ty == dioc_pkg::OUT_PULSE) begin
						next_out_act[j] = 1'b1;
						// active from the cycle after start for exactly out_time cycles
						if (out_cnt[j] >= out_time[j]) begin
							next_out_act[j] = 1'b0;
							next_out_ph[j]  = dioc_pkg::PH_IDLE;
							next_out_cfg[j][dioc_pkg::OC_CMD] = 1'b0;
						end
					end else if (ty == dioc_pkg::OUT_PWM) begin
						// period and high time in cycles set frequency and duty
						next_out_act[j] = out_cnt[j] < out_on[j];
						if (out_cnt[j] + 32'h0000_0001 >= out_time[j]) next_out_cnt[j] = 32'h0000_0000;
					end else begin
						next_out_act[j] = 1'b1;
						next_out_cnt[j] = out_cnt[j];
					end
				end
				default: begin
					next_out_ph[j] = dioc_pkg::PH_IDLE;
				end
			endcase
			next_pin[j] = next_out_cfg[j][dioc_pkg::OC_POL] ? next_out_act[j] : !next_out_act[j];
			if (acc && !PWRITE) begin
				if (a == dioc_pkg::ADDR_OUT_CFG + 12'(16 * j)) begin
					next_rdata = out_cfg[j];
					next_rdata[dioc_pkg::OC_ACTIVE] = out_act[j];
					rd_hit = 1'b1;
				end
				if (a == dioc_pkg::ADDR_OUT_TIME + 12'(16 * j)) begin
					next_rdata = out_time[j];
					rd_hit     = 1'b1;
				end
				if (a == dioc_pkg::ADDR_OUT_ON + 12'(16 * j)) begin
					next_rdata = out_on[j];
					rd_hit     = 1'b1;
				end
				if (a == dioc_pkg::ADDR_OUT_DLY + 12'(16 * j)) begin
					next_rdata = out_dly[j];
					rd_hit     = 1'b1;
				end
			end
		end
		if (acc && !PWRITE && a == dioc_pkg::ADDR_IN_STATE) begin
			next_rdata = {{(32 - NI){1'b0}}, in_state};
			rd_hit     = 1'b1;
		end
		if (acc && !PWRITE && a == dioc_pkg::ADDR_ANA_RNG) begin
			next_rdata = {30'h0, ana_rng};
			rd_hit     = 1'b1;
		end
		// unmapped or misaligned reads answer with an error
		next_slverr = acc && !PWRITE && !rd_hit;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < NI; i++) begin
				in_cfg[i]    <= dioc_pkg::RST_WORD;
				in_cnt[i]    <= dioc_pkg::RST_WORD;
				latch_val[i] <= dioc_pkg::RST_WORD;
				deb_cnt[i]   <= 16'h0000;
			end
			for (int j = 0; j < NO; j++) begin
				out_cfg[j]  <= dioc_pkg::RST_WORD;
				out_time[j] <= dioc_pkg::RST_WORD;
				out_on[j]   <= dioc_pkg::RST_WORD;
				out_dly[j]  <= dioc_pkg::RST_WORD;
				out_cnt[j]  <= dioc_pkg::RST_WORD;
				out_ph[j]   <= dioc_pkg::PH_IDLE;
			end
			latch_full <= '0;
			in_state   <= '0;
			in_prev    <= '0;
			ana_rng    <= 2'h0;
			out_act    <= '0;
			// reset polarity is active low, so the inactive pin level is high
			pin        <= '1;
			rdata      <= dioc_pkg::RST_WORD;
			ready      <= 1'b0;
			slverr     <= 1'b0;
		end else begin
			in_cfg     <= next_in_cfg;
			in_cnt     <= next_in_cnt;
			latch_val  <= next_latch_val;
			deb_cnt    <= next_deb_cnt;
			out_cfg    <= next_out_cfg;
			out_time   <= next_out_time;
			out_on     <= next_out_on;
			out_dly    <= next_out_dly;
			out_cnt    <= next_out_cnt;
			out_ph     <= next_out_ph;
			latch_full <= next_latch_full;
			in_state   <= next_in_state;
			in_prev    <= in_state;
			ana_rng    <= next_ana_rng;
			out_act    <= next_out_act;
			pin        <= next_pin;
			rdata      <= next_rdata;
			ready      <= next_ready;
			slverr     <= next_slverr;
		end
	end

	assign PRDATA           = rdata;
	assign PREADY           = ready;
	assign PSLVERR          = slverr;
	assign GENERAL_OUTPUT   = pin;
	assign ANALOG_RANGE_SEL = ana_rng;
endmodule : dioc_top
`default_nettype wire

// ---- bench/dioc_monitor.sv ----
// checker on the dioc_top ports
// assumes bind to dioc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dioc_monitor (
	input wire logic                         REF_CLK,
	input wire logic                         RESET_N,
	input wire logic [11:0]                  PADDR,
	input wire logic                         PSEL,
	input wire logic                         PENABLE,
	input wire logic                         PWRITE,
	input wire logic [31:0]                  PWDATA,
	input wire logic [31:0]                  PRDATA,
	input wire logic                         PREADY,
	input wire logic                         PSLVERR,
	input wire logic [dioc_pkg::NUM_IN-1:0]  GENERAL_INPUT_N,
	input wire logic [31:0]                  AXIS_POSITION,
	input wire logic [dioc_pkg::NUM_OUT-1:0] GENERAL_OUTPUT,
	input wire logic [1:0]                   ANALOG_RANGE_SEL
);
	// --------
	// last completed write, held until the next one
	// --------
	logic        wv, next_wv;
	logic [11:0] wa, next_wa;
	logic [31:0] wd, next_wd;
	always_comb begin
		next_wv = RESET_N && PSEL && PENABLE && PREADY && PWRITE;
		next_wa = next_wv ? PADDR : wa;
		next_wd = next_wv ? PWDATA : wd;
	end
	always_ff @(posedge REF_CLK) begin
		wv <= next_wv;
		wa <= next_wa;
		wd <= next_wd;
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	ready_wait_a: assert property ($rose(PSEL && PENABLE) |=> PREADY) else $error("no ready after wait");
	ready_cause_a: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE))
		else $error("ready without access");
	err_write_a: assert property (PREADY && PWRITE |-> !PSLVERR) else $error("error on write");
	err_unmap_a: assert property (PREADY && !PWRITE && PADDR == 12'hffc |-> PSLVERR) else $error("no error");
	range_copy_a: assert property (wv && wa == dioc_pkg::ADDR_ANA_RNG |-> ##1
		ANALOG_RANGE_SEL == wd[1:0]) else $error("range pins wrong");
	out_state_a: assert property (wv && wa == dioc_pkg::ADDR_OUT_CFG && wd[2:1] == 2'h0 |->
		##[1:2] GENERAL_OUTPUT[0] == (wd[3] ^ !wd[0])) else $error("state pin wrong");
	reset_quiet_a: assert property ($rose(RESET_N) |-> !PREADY && !PSLVERR && PRDATA == 32'h0)
		else $error("bus not quiet after reset");
endmodule : dioc_monitor
bind dioc_top dioc_monitor dioc_monitor_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PADDR(PADDR),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .GENERAL_INPUT_N(GENERAL_INPUT_N),
	.AXIS_POSITION(AXIS_POSITION), .GENERAL_OUTPUT(GENERAL_OUTPUT), .ANALOG_RANGE_SEL(ANALOG_RANGE_SEL));
`default_nettype wire

// ---- bench/dioc_partner.sv ----
// actuator model: run lengths of one output pin
// assumes the pin is sampled on the block clock
`timescale 1ns/1ps
`default_nettype none
module dioc_partner (
	input  wire logic        clk,
	input  wire logic        pin,
	output var  logic [15:0] hi_len,
	output var  logic [15:0] lo_len
);
	// --------
	// run counter, only whole runs reported
	// --------
	logic        last   = 1'b0;
	logic [15:0] run    = 16'h0;
	logic [15:0] hi_run = 16'h0;
	logic [15:0] lo_run = 16'h0;
	assign hi_len = hi_run;
	assign lo_len = lo_run;
	always @(posedge clk) begin
		last <= pin;
		run <= (pin !== last) ? 16'h1 : run + 16'h1;
		if (pin !== last && last === 1'b1)
			hi_run <= run;
		if (pin !== last && last === 1'b0)
			lo_run <= run;
	end
endmodule : dioc_partner
`default_nettype wire

// ---- bench/tb_drive_io_port_config.sv ----
// bench for dioc_top: apb tasks, pins, partner
// assumes dioc_monitor is bound by its own file
`timescale 1ns/1ps
`default_nettype none
module tb_drive_io_port_config;
	// --------
	// signals and instances
	// --------
	localparam logic [11:0] IC = dioc_pkg::ADDR_IN_CFG;
	localparam logic [11:0] O1 = dioc_pkg::ADDR_OUT_CFG + 12'h10;
	logic        REF_CLK = 1'b0;
	logic        RESET_N = 1'b0;
	logic [11:0] PADDR   = 12'h0;
	logic        PSEL    = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE  = 1'b0;
	logic [31:0] PWDATA  = 32'h0;
	logic [3:0]  GENERAL_INPUT_N = 4'h0;
	logic [31:0] AXIS_POSITION   = 32'h0;
	logic [31:0] PRDATA, q;
	logic        PREADY, PSLVERR, err;
	logic [1:0]  GENERAL_OUTPUT, ANALOG_RANGE_SEL;
	logic [15:0] hi_len, lo_len;
	logic [31:0] ow [5] = '{32'h9, 32'hb, 32'h1, 32'h8, 32'h0};
	logic        op [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	int          miscompares = 0;
	int          cmp_count   = 0;
	always #20 REF_CLK = ~REF_CLK;
	dioc_top dioc_top_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PADDR(PADDR), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .GENERAL_INPUT_N(GENERAL_INPUT_N), .AXIS_POSITION(AXIS_POSITION),
		.GENERAL_OUTPUT(GENERAL_OUTPUT), .ANALOG_RANGE_SEL(ANALOG_RANGE_SEL));
	dioc_partner dioc_partner_i (.clk(REF_CLK), .pin(GENERAL_OUTPUT[1]), .hi_len(hi_len), .lo_len(lo_len));
	// --------
	// tasks
	// --------
	task automatic final_report();
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask : tick
	// one apb transfer; request held until ready is seen at an edge
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge REF_CLK);
		PADDR <= a;
		PWRITE <= w;
		PWDATA <= d;
		PSEL <= 1'b1;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 16) begin
			miscompares++;
			final_report();
		end
	endtask : xfer
	// --------
	// sequence
	// --------
	initial begin
		tick(12);
		RESET_N <= 1'b1;
		tick(4);
		check(GENERAL_OUTPUT, 2'h3);
		for (int k = 0; k < 4; k++) begin
			xfer(IC, 1'b1, 32'(k[1]));
			GENERAL_INPUT_N[0] <= k[0];
			tick(8);
			xfer(dioc_pkg::ADDR_IN_STATE, 1'b0, 32'h0);
			check(q[0], !(k[1] ^ k[0]));
		end
		xfer(IC + 12'h4, 1'b1, 32'h1);
		tick(8);
		for (int e = 1; e < 4; e++) begin
			xfer(IC + 12'h4, 1'b1, 32'h81);
			xfer(IC + 12'h4, 1'b1, 32'(32'h3 | (e << 2)));
			GENERAL_INPUT_N[1] <= 1'b1;
			tick(8);
			GENERAL_INPUT_N[1] <= 1'b0;
			tick(8);
			xfer(dioc_pkg::ADDR_IN_CNT + 12'h4, 1'b0, 32'h0);
			check(q, (e == 3) ? 32'h2 : 32'h1);
		end
		AXIS_POSITION <= 32'h1234_5678;
		xfer(IC + 12'h8, 1'b1, 32'h51);
		tick(8);
		GENERAL_INPUT_N[2] <= 1'b1;
		tick(8);
		AXIS_POSITION <= 32'h0abc_def0;
		GENERAL_INPUT_N[2] <= 1'b0;
		tick(8);
		xfer(dioc_pkg::ADDR_LATCH + 12'h8, 1'b0, 32'h0);
		check(q, 32'h1234_5678);
		xfer(IC + 12'hc, 1'b1, 32'h0014_0001);
		tick(30);
		GENERAL_INPUT_N[3] <= 1'b1;
		tick(4);
		GENERAL_INPUT_N[3] <= 1'b0;
		tick(4);
		xfer(dioc_pkg::ADDR_IN_STATE, 1'b0, 32'h0);
		check(q[3], 1'b1);
		tick(30);
		xfer(dioc_pkg::ADDR_IN_STATE, 1'b0, 32'h0);
		check(q[3], 1'b0);
		for (int r = 1; r < 3; r++) begin
			xfer(dioc_pkg::ADDR_ANA_RNG, 1'b1, 32'(r));
			tick(2);
			check(ANALOG_RANGE_SEL, 32'(r));
			xfer(dioc_pkg::ADDR_ANA_RNG, 1'b0, 32'h0);
			check(q, 32'(r));
		end
		xfer(12'hffc, 1'b1, 32'h1);
		xfer(12'hffc, 1'b0, 32'h0);
		check(err, 1'b1);
		foreach (ow[i]) begin
			xfer(dioc_pkg::ADDR_OUT_CFG, 1'b1, ow[i]);
			tick(40);
			check(GENERAL_OUTPUT[0], op[i]);
			xfer(dioc_pkg::ADDR_OUT_CFG, 1'b0, 32'h0);
			check(q & 32'h6, 32'h0);
		end
		xfer(O1 + 12'h4, 1'b1, 32'd10);
		xfer(O1, 1'b1, 32'h3);
		xfer(O1, 1'b1, 32'hb);
		tick(40);
		check(hi_len, 16'd10);
		xfer(O1, 1'b0, 32'h0);
		check(q & 32'h1e, 32'h2);
		xfer(O1 + 12'h8, 1'b1, 32'd4);
		xfer(O1 + 12'hc, 1'b1, 32'd7);
		xfer(O1, 1'b1, 32'h5);
		xfer(O1, 1'b1, 32'hd);
		tick(60);
		check(hi_len, 16'd4);
		check(lo_len, 16'd6);
		xfer(O1, 1'b1, 32'h5);
		tick(4);
		xfer(O1, 1'b1, 32'h1);
		xfer(O1, 1'b0, 32'h0);
		check(q & 32'h6, 32'h0);
		final_report();
	end
endmodule : tb_drive_io_port_config
`default_nettype wire
